// ==== design/tone_card_port.sv ====
`timescale 1ns/100ps
module tone_card_port (
    tone_port_if.card          BUS,
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic [9:0]    CARD_ADDR,
    input  wire logic [2:0]    PORT_ADDR,
    input  wire logic          PROC_READ_STROBE_N,
    input  wire logic          PROC_WRITE_STROBE_N,
    input  wire logic [7:0]    PROC_D_IN,
    input  wire logic          PROC_IRQ_FLAG_N,
    output logic [7:0]         PROC_D_OUT,
    output logic               PROC_D_OE_N,
    output logic               PROC_INT,
    output logic               PROC_RESET_IN_N
);
    // Decoding
    logic       host_sel;
    logic       host_rd;
    logic       host_wr;
    logic       host_wr_rise;
    logic       proc_wr_act;
    logic       proc_wr_rise;
    logic       proc_read_decode;
    logic       proc_write_decode;
    logic       port_addr_bit2;
    logic       port_addr_bit1;
    logic [9:0] addr_hit;

    // State and next values
    logic       iow_d_r;
    logic       iow_d_nxt;
    logic       pwe_d_r;
    logic       pwe_d_nxt;
    logic [7:0] to_proc_r;
    logic [7:0] to_proc_nxt;
    logic [7:0] to_host_r;
    logic [7:0] to_host_nxt;
    logic [7:0] host_out_r;
    logic [7:0] host_out_nxt;
    logic       host_oe_n_r;
    logic       host_oe_n_nxt;
    logic       flag_r;
    logic       flag_nxt;

    // Next values of the top-level outputs
    logic       proc_int_nxt;
    logic [7:0] proc_d_out_nxt;
    logic       proc_d_oe_n_nxt;
    logic       proc_reset_in_n_nxt;

    // One place decides which processor port a strobe belongs to
    function automatic logic port_is(input logic [2:0] port, input logic [2:0] want);
        port_is = (port == want);
    endfunction

    // Every address line takes part, so the card has no alias elsewhere
    for (genvar i = 0; i < 10; i++) begin : g_addr
        assign addr_hit[i] = (BUS.sa[i] == CARD_ADDR[i]);
    end

    assign port_addr_bit2      = PORT_ADDR[2];
    assign port_addr_bit1      = PORT_ADDR[1];
    assign host_sel            = (&addr_hit) && !BUS.aen;
    assign host_rd             = host_sel && !BUS.ior_n;
    assign host_wr             = host_sel && !BUS.iow_n;
    assign proc_read_decode    = port_addr_bit2 && !PROC_READ_STROBE_N
                                 && port_is(PORT_ADDR, tone_port_pkg::PROC_DATA_PORT);
    assign proc_write_decode   = port_addr_bit2 && port_addr_bit1
                                 && port_is(PORT_ADDR, tone_port_pkg::PROC_STATUS_PORT);
    assign proc_wr_act         = proc_write_decode && !PROC_WRITE_STROBE_N;
    // Strobe release is seen one clock late; the writer must still hold its byte then
    assign host_wr_rise        = iow_d_r && !host_wr;
    assign proc_wr_rise        = pwe_d_r && PROC_WRITE_STROBE_N;
    assign iow_d_nxt           = host_wr;
    assign pwe_d_nxt           = proc_wr_act;
    assign to_proc_nxt         = host_wr_rise ? BUS.host_d_in : to_proc_r;
    assign to_host_nxt         = proc_wr_rise ? PROC_D_IN : to_host_r;
    assign proc_int_nxt        = host_wr_rise;
    assign proc_d_out_nxt      = to_proc_r;
    assign proc_d_oe_n_nxt     = !proc_read_decode;
    assign host_out_nxt        = to_host_r;
    assign host_oe_n_nxt       = !host_rd;
    // Firmware builds the flag from enabled status bits; the card only passes it on
    assign flag_nxt            = PROC_IRQ_FLAG_N;
    assign proc_reset_in_n_nxt = !BUS.reset_drv;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            iow_d_r <= 1'b0;
        end else begin
            iow_d_r <= iow_d_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pwe_d_r <= 1'b0;
        end else begin
            pwe_d_r <= pwe_d_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            to_proc_r <= tone_port_pkg::RESET_BYTE;
        end else begin
            to_proc_r <= to_proc_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            to_host_r <= tone_port_pkg::RESET_BYTE;
        end else begin
            to_host_r <= to_host_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PROC_INT <= 1'b0;
        end else begin
            PROC_INT <= proc_int_nxt;
        end
    end

    // Output data follows the latch always; only the enable marks the read window
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PROC_D_OUT <= tone_port_pkg::RESET_BYTE;
        end else begin
            PROC_D_OUT <= proc_d_out_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PROC_D_OE_N <= 1'b1;
        end else begin
            PROC_D_OE_N <= proc_d_oe_n_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            host_out_r <= tone_port_pkg::RESET_BYTE;
        end else begin
            host_out_r <= host_out_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            host_oe_n_r <= 1'b1;
        end else begin
            host_oe_n_r <= host_oe_n_nxt;
        end
    end

    // Flag reads inactive while in reset; the host still ignores it for a while after
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            flag_r <= 1'b1;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PROC_RESET_IN_N <= 1'b0;
        end else begin
            PROC_RESET_IN_N <= proc_reset_in_n_nxt;
        end
    end

    // Host data held during the host's read window, processor does the rest
    assign BUS.host_d_out        = host_out_r;
    assign BUS.host_d_oe_n       = host_oe_n_r;
    assign BUS.host_irq_flag_out = flag_r;
endmodule // tone_card_port

// ==== design/tone_host_port.sv ====
`timescale 1ns/100ps
module tone_host_port #(
    parameter int GAP_CYC    = tone_port_pkg::ACCESS_GAP_CYC,
    parameter int IGNORE_CYC = tone_port_pkg::IRQ_IGNORE_CYC
) (
    tone_port_if.host          BUS,
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic [9:0]    CARD_ADDR,
    input  wire logic          REQ,
    input  wire logic          REQ_RD,
    input  wire logic [3:0]    REQ_REG,
    input  wire logic [7:0]    REQ_DATA,
    output logic               BUSY,
    output logic               DONE,
    output logic [7:0]         RESULT,
    output logic [7:0]         STATUS,
    output logic               IRQ_VALID_N
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_WR = 3'b001, S_GAP = 3'b011, S_RD = 3'b010, S_NEXT = 3'b110
    } step_t;
    step_t       st_r;
    logic [1:0]  phase_r;
    logic [1:0]  pulse_r;
    logic [31:0] cnt_r;
    logic [31:0] ign_r;
    logic        rd_r;
    logic [7:0]  byte_r;
    logic [7:0]  second_r;
    logic        gap_done;

    assign gap_done = (cnt_r == 32'(GAP_CYC));

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_r <= S_IDLE; phase_r <= 2'h0; pulse_r <= 2'h0; cnt_r <= '0; ign_r <= '0;
            rd_r <= 1'b0; byte_r <= 8'h00; second_r <= 8'h00;
            BUSY <= 1'b0; DONE <= 1'b0; RESULT <= 8'h00; STATUS <= 8'h00; IRQ_VALID_N <= 1'b1;
            BUS.iow_n <= 1'b1; BUS.ior_n <= 1'b1; BUS.host_d_in <= 8'h00;
        end else begin
            DONE <= 1'b0;
            if (ign_r != 32'(IGNORE_CYC)) ign_r <= ign_r + 32'h1;
            IRQ_VALID_N <= (ign_r == 32'(IGNORE_CYC)) ? BUS.host_irq_flag_out : 1'b1;
            unique case (st_r)
                S_IDLE: if (REQ) begin
                    rd_r <= REQ_RD; BUSY <= 1'b1; phase_r <= 2'h0; pulse_r <= 2'h0;
                    byte_r <= tone_port_pkg::make_cmd(REQ_RD, REQ_REG);
                    second_r <= REQ_RD ? tone_port_pkg::make_cmd(1'b1, 4'h0) : REQ_DATA;
                    st_r <= S_WR;
                end
                S_WR: begin
                    pulse_r <= pulse_r + 2'h1;
                    BUS.host_d_in <= byte_r;
                    BUS.iow_n <= (pulse_r == 2'h3);
                    if (pulse_r == 2'h3) begin cnt_r <= '0; st_r <= S_GAP; end
                end
                S_GAP: begin
                    cnt_r <= cnt_r + 32'h1;
                    if (gap_done) begin pulse_r <= 2'h0; st_r <= S_RD; end
                end
                S_RD: begin
                    pulse_r <= pulse_r + 2'h1;
                    BUS.ior_n <= (pulse_r == 2'h3);
                    if (pulse_r == 2'h2) begin
                        if (phase_r == 2'h0 && rd_r) RESULT <= BUS.host_d_out;
                        if (phase_r == 2'h1) STATUS <= BUS.host_d_out;
                    end
                    if (pulse_r == 2'h3) st_r <= S_NEXT;
                end
                S_NEXT: if (phase_r == 2'h0) begin
                    phase_r <= 2'h1; pulse_r <= 2'h0; byte_r <= second_r; st_r <= S_WR;
                end else begin
                    BUSY <= 1'b0; DONE <= 1'b1; st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    assign BUS.sa        = CARD_ADDR;
    assign BUS.aen       = 1'b0;
    assign BUS.reset_drv = RESET;
endmodule // tone_host_port

// ==== design/tone_port_if.sv ====
`timescale 1ns/100ps
interface tone_port_if;
    logic [9:0] sa;
    logic [7:0] host_d_in;
    logic [7:0] host_d_out;
    logic       host_d_oe_n;
    logic       ior_n;
    logic       iow_n;
    logic       aen;
    logic       reset_drv;
    logic       host_irq_flag_out;

    modport card (
        input  sa, host_d_in, ior_n, iow_n, aen, reset_drv,
        output host_d_out, host_d_oe_n, host_irq_flag_out
    );
    modport host (
        output sa, host_d_in, ior_n, iow_n, aen, reset_drv,
        input  host_d_out, host_d_oe_n, host_irq_flag_out
    );
endinterface

// ==== design/tone_port_pkg.sv ====
package tone_port_pkg;
    localparam logic [9:0]  BASE_ADDR_DEFAULT = 10'h300;
    localparam logic [9:0]  ADDR_MAX          = 10'h3FF;
    localparam logic [2:0]  PROC_DATA_PORT    = 3'h4;
    localparam logic [2:0]  PROC_STATUS_PORT  = 3'h6;
    localparam logic [2:0]  CMD_PREFIX        = 3'h7;
    localparam int          CMD_PREFIX_MSB    = 7;
    localparam int          CMD_PREFIX_LSB    = 5;
    localparam int          CMD_DIR_BIT       = 4;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    localparam int          CLK_MHZ           = 25;
    localparam int          ACCESS_GAP_US     = 20;
    localparam int          ACCESS_GAP_CYC    = ACCESS_GAP_US * CLK_MHZ;
    localparam int          IRQ_IGNORE_MS     = 2;
    localparam int          IRQ_IGNORE_CYC    = IRQ_IGNORE_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_SEND = 2'b01,
        HOST_WAIT = 2'b11,
        HOST_READ = 2'b10
    } host_state_t;

    function automatic logic [7:0] make_cmd(input logic rd, input logic [3:0] reg_num);
        make_cmd = {CMD_PREFIX, rd, reg_num};
    endfunction
endpackage

// ==== tb/tb_tone_detector_host_port.sv ====
`timescale 1ns/100ps
module tb_tone_detector_host_port;
    logic       clk, rst, req, req_rd, busy, done, irq_n, flag_n;
    logic       rd_n, wr_n, pint, oe_n, rsn;
    logic [2:0] port;
    logic [3:0] reg_n;
    logic [7:0] req_d, pd_in, pd_out, result, status;
    int         err_total, n_compared;
    tone_port_if bus ();
    tone_card_port i_tone_card_port (.BUS(bus.card), .CLK(clk), .RESET(rst), .CARD_ADDR(10'h300), .PORT_ADDR(port),
        .PROC_READ_STROBE_N(rd_n), .PROC_WRITE_STROBE_N(wr_n), .PROC_D_IN(pd_in), .PROC_IRQ_FLAG_N(flag_n),
        .PROC_D_OUT(pd_out), .PROC_D_OE_N(oe_n), .PROC_INT(pint), .PROC_RESET_IN_N(rsn));
    tone_host_port #(.GAP_CYC(20), .IGNORE_CYC(16)) i_tone_host_port (.BUS(bus.host), .CLK(clk), .RESET(rst),
        .CARD_ADDR(10'h300), .REQ(req), .REQ_RD(req_rd), .REQ_REG(reg_n), .REQ_DATA(req_d), .BUSY(busy),
        .DONE(done), .RESULT(result), .STATUS(status), .IRQ_VALID_N(irq_n));
    tone_port_properties i_tone_port_properties (.CLK(clk), .RESET(rst), .sa(bus.sa), .host_d_in(bus.host_d_in),
        .host_d_oe_n(bus.host_d_oe_n), .ior_n(bus.ior_n), .iow_n(bus.iow_n), .aen(bus.aen));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Stands in for the firmware: one interrupt, read port 4, answer on port 6
    task automatic serve(input logic [7:0] exp, input logic [7:0] reply);
        for (int i = 0; i < 100 && pint !== 1'b1; i++) @(posedge clk);
        chk({7'h00, pint}, 8'h01);
        port <= 3'h4;
        rd_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(pd_out, exp);
        chk({7'h00, oe_n}, 8'h00);
        rd_n <= 1'b1;
        port <= 3'h6;
        pd_in <= reply;
        wr_n <= 1'b0;
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic host_op(input logic rd, input logic [3:0] r, input logic [7:0] d, first, last);
        fork
            begin
                req <= 1'b1;
                req_rd <= rd;
                reg_n <= r;
                req_d <= d;
                @(posedge clk);
                req <= 1'b0;
                for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
                chk({7'h00, done}, 8'h01);
            end
            begin
                serve({3'h7, rd, r}, first);
                serve(rd ? 8'hF0 : d, last);
            end
        join
        chk(status, last);
        if (rd) chk(result, first);
        repeat (2) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        {rst, rd_n, wr_n} = 3'h7;
        {req, req_rd, flag_n, port, reg_n, req_d, pd_in} = '0;
        repeat (4) @(posedge clk);
        chk({7'h00, rsn}, 8'h00);
        rst <= 1'b0;
        @(posedge clk);
        chk({7'h00, irq_n}, 8'h01);
        host_op(1'b0, 4'h0, 8'hA5, 8'h11, 8'h7E);
        host_op(1'b0, 4'hF, 8'h3C, 8'h22, 8'h5A);
        host_op(1'b1, 4'h1, 8'h00, 8'hC3, 8'h6B);
        host_op(1'b1, 4'hF, 8'h00, 8'h96, 8'hFF);
        chk({7'h00, rsn}, 8'h01);
        chk({7'h00, irq_n}, 8'h00);
        summarize();
    end
endmodule // tb_tone_detector_host_port

// ==== tb/tone_port_properties.sv ====
`timescale 1ns/100ps
module tone_port_properties (
    input wire logic       CLK,
    input wire logic       RESET,
    input wire logic [9:0] sa,
    input wire logic [7:0] host_d_in,
    input wire logic       host_d_oe_n,
    input wire logic       ior_n,
    input wire logic       iow_n,
    input wire logic       aen
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_drive_in_read: assert property (!host_d_oe_n |-> !$past(ior_n)) else $error("card drives bus outside read");
    a_read_answer: assert property (!ior_n && !aen |=> !host_d_oe_n) else $error("card ignored host read");
    a_card_addr: assert property (!ior_n || !iow_n |-> sa == 10'h300) else $error("strobe at foreign address");
    a_dma_idle: assert property (!aen) else $error("address enable raised");
    a_write_len: assert property ($fell(iow_n) |-> !iow_n[*3] ##1 iow_n) else $error("write strobe length");
    a_read_len: assert property ($fell(ior_n) |-> !ior_n[*3] ##1 ior_n) else $error("read strobe length");
    a_no_overlap: assert property (ior_n || iow_n) else $error("read and write strobes overlap");
    a_read_spacing: assert property ($rose(iow_n) |-> ior_n[*8]) else $error("read too soon after write");
    a_data_hold: assert property (!iow_n && !$fell(iow_n) |-> $stable(host_d_in)) else $error("write data moved");
    c_write: cover property ($rose(iow_n));
    c_read: cover property ($rose(ior_n));
    c_drive: cover property (!host_d_oe_n);
endmodule // tone_port_properties
